/* File: hdl/vss_sync_source_select.sv */
// sync source selection, line lock phase comparator and vertical phase shift
// assumes pins are asynchronous and slow against SYS_CLK; register port on SYS_CLK
//
// Behaviour
// - sync source select 0 gives internal sync if pll path select is also 0, 1 gives mains line lock.
// - line lock compares mains reference against vertical pulse from master clock.
// - phase compare output polarity inverts when the invert bit is set.
// - vertical phase is low byte plus two upper bits, updated by shift.
// - shift preset loads vertical phase from preset low byte and upper bits.
// - auto switching picks line lock when mains present, internal when absent.
// - port pins select crystal or line lock oscillator as master clock.
// - subcarrier lock is never claimed while in line lock.
// - pll path select 0 gives internal sync if sync source select is also 0, 1 gives line lock.
// - auto switch enable 0 turns automatic switching off, 1 on.
// - internal mode compares crystal line pulse against master line pulse.
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps

module vss_sync_source_select #(
    parameter int unsigned MAINS_TIMEOUT_CYCLES = vss_pkg::MAINS_TIMEOUT_CYC
) (
    input  wire logic                         SYS_CLK,
    input  wire logic                         SYS_RST,
    input  wire vss_pkg::vss_bus_req_type     BUS_REQ,
    output      logic [vss_pkg::DATA_W-1:0]   RD_DATA,
    input  wire logic                         REFERENCE_CRYSTAL_CLOCK,
    input  wire logic                         MASTER_VIDEO_CLOCK,
    input  wire logic                         MAINS_REFERENCE_INPUT,
    output      logic                         PHASE_COMPARE_OUT,
    output      logic                         CLK_SRC_LINE_LOCK,
    output      logic                         CLK_SRC_CRYSTAL,
    output      logic [3:0]                   CLOCK_SYSTEM_SELECT,
    output      logic                         MAINS_LOCKED_SYNC,
    output      logic                         SUBCARRIER_LOCKED,
    output      logic                         DIVIDED_VERTICAL_PULSE
);
    import vss_pkg::*;

    function automatic logic [3:0] clock_code(input logic ll, input logic pal,
                                              input logic p760);
        logic [3:0] c;
        c = CODE_INT_NTSC_510;
        case ({ll, pal, p760})
            3'b000:  c = CODE_INT_NTSC_510;
            3'b001:  c = CODE_INT_NTSC_760;
            3'b010:  c = CODE_INT_PAL_510;
            3'b011:  c = CODE_INT_PAL_760;
            3'b100:  c = CODE_LL_NTSC_510;
            3'b101:  c = CODE_LL_NTSC_760;
            3'b110:  c = CODE_LL_PAL_510;
            3'b111:  c = CODE_LL_PAL_760;
            default: c = CODE_INT_NTSC_510;
        endcase
        return c;
    endfunction : clock_code

    function automatic logic [LINE_CNT_W-1:0] wrap_inc(input logic [LINE_CNT_W-1:0] v,
                                                      input logic [LINE_CNT_W-1:0] lim);
        logic [LINE_CNT_W-1:0] n;
        n = v + 12'h001;
        if (n >= lim) begin
            n = 12'h000;
        end
        return n;
    endfunction : wrap_inc

    // index 0 crystal, 1 master clock, 2 mains reference
    logic [2:0]                 sync1_q;
    logic [2:0]                 sync2_q;
    logic [2:0]                 prev_q;
    logic [2:0]                 rise;

    vss_ctrl_type               ctrl_q;
    logic [VPHASE_W-1:0]        vphase_q;
    logic [VPHASE_W-1:0]        vphase_d;
    logic [VPHASE_W-1:0]        preset_q;
    logic [TIMEOUT_CNT_W-1:0]   idle_cnt_q;
    logic                       present_q;
    logic                       line_lock;
    logic [LINE_CNT_W-1:0]      xtal_div_q;
    logic [LINE_CNT_W-1:0]      mclk_div_q;
    logic [LINE_CNT_W-1:0]      vline_q;
    logic                       xtal_line_q;
    logic                       mclk_line_q;
    logic                       vpulse_q;
    logic                       cmp_ref;
    logic                       cmp_fb;
    logic                       pc_q;
    logic                       wr_ctrl;
    logic                       wr_vshift;
    logic                       wr_preset;
    logic                       wr_cmd;
    logic [DATA_W-1:0]          status;

    // the first stage only feeds the second; edges come from the second stage
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            prev_q  <= 3'h0;
        end else begin
            sync1_q <= {MAINS_REFERENCE_INPUT, MASTER_VIDEO_CLOCK, REFERENCE_CRYSTAL_CLOCK};
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    assign rise = sync2_q & ~prev_q;

    assign wr_ctrl   = BUS_REQ.wr && (BUS_REQ.addr == ADDR_CTRL);
    assign wr_vshift = BUS_REQ.wr && (BUS_REQ.addr == ADDR_VSHIFT);
    assign wr_preset = BUS_REQ.wr && (BUS_REQ.addr == ADDR_PRESET);
    assign wr_cmd    = BUS_REQ.wr && (BUS_REQ.addr == ADDR_SHIFT_CMD);

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            ctrl_q <= vss_ctrl_type'(CTRL_RESET);
        end else if (wr_ctrl) begin
            ctrl_q.sync_source_select <= BUS_REQ.wdata[CTRL_SYNC_SRC_BIT];
            ctrl_q.auto_switch_enable <= BUS_REQ.wdata[CTRL_AUTO_BIT];
            ctrl_q.pll_path_select    <= BUS_REQ.wdata[CTRL_PLL_PATH_BIT];
            ctrl_q.phase_out_invert   <= BUS_REQ.wdata[CTRL_INVERT_BIT];
            ctrl_q.pal                <= BUS_REQ.wdata[CTRL_PAL_BIT];
            ctrl_q.pix760             <= BUS_REQ.wdata[CTRL_PIX760_BIT];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            preset_q <= PRESET_RESET;
        end else if (wr_preset) begin
            preset_q <= BUS_REQ.wdata[VPHASE_W-1:0];
        end
    end

    // preset beats a direct write, which beats a single step
    always_comb begin
        vphase_d = vphase_q;
        if (wr_cmd && BUS_REQ.wdata[CMD_PRESET_BIT]) begin
            vphase_d = preset_q;
        end else if (wr_vshift) begin
            vphase_d = BUS_REQ.wdata[VPHASE_W-1:0];
        end else if (wr_cmd && BUS_REQ.wdata[CMD_UP_BIT]) begin
            vphase_d = vphase_q + 10'h001;
        end else if (wr_cmd && BUS_REQ.wdata[CMD_DOWN_BIT]) begin
            vphase_d = vphase_q - 10'h001;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            vphase_q <= VPHASE_RESET;
        end else begin
            vphase_q <= vphase_d;
        end
    end

    // mains counts as absent once no rising edge is seen for the timeout
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            idle_cnt_q <= '0;
            present_q  <= 1'b0;
        end else if (rise[2]) begin
            idle_cnt_q <= '0;
            present_q  <= 1'b1;
        end else if (idle_cnt_q >= TIMEOUT_CNT_W'(MAINS_TIMEOUT_CYCLES)) begin
            present_q  <= 1'b0;
        end else begin
            idle_cnt_q <= idle_cnt_q + 24'h000001;
        end
    end

    // either manual bit asks for line lock; auto mode follows the mains detector
    assign line_lock = ctrl_q.auto_switch_enable ? present_q
                     : (ctrl_q.sync_source_select | ctrl_q.pll_path_select);

    // line pulse dividers; inputs are sampled, so clocks near SYS_CLK rate alias
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            xtal_div_q  <= '0;
            xtal_line_q <= 1'b0;
        end else begin
            xtal_line_q <= 1'b0;
            if (rise[0]) begin
                xtal_div_q  <= wrap_inc(xtal_div_q, XTAL_LINE_DIV);
                xtal_line_q <= (xtal_div_q == 12'h000);
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            mclk_div_q  <= '0;
            mclk_line_q <= 1'b0;
        end else begin
            mclk_line_q <= 1'b0;
            if (rise[1]) begin
                mclk_div_q  <= wrap_inc(mclk_div_q, MASTER_LINE_DIV);
                mclk_line_q <= (mclk_div_q == 12'h000);
            end
        end
    end

    // vertical pulse fires at the line that matches the phase offset
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            vline_q  <= '0;
            vpulse_q <= 1'b0;
        end else begin
            vpulse_q <= 1'b0;
            if (mclk_line_q) begin
                vline_q  <= wrap_inc(vline_q, LINES_PER_FIELD);
                vpulse_q <= (vline_q == {2'b00, vphase_q});
            end
        end
    end

    assign cmp_ref = line_lock ? rise[2] : xtal_line_q;
    assign cmp_fb  = line_lock ? vpulse_q : mclk_line_q;

    // set on the reference edge, cleared on the feedback edge; reference wins a tie
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            pc_q <= 1'b0;
        end else if (cmp_ref) begin
            pc_q <= 1'b1;
        end else if (cmp_fb) begin
            pc_q <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            PHASE_COMPARE_OUT      <= 1'b0;
            CLK_SRC_LINE_LOCK      <= 1'b0;
            CLK_SRC_CRYSTAL        <= 1'b1;
            CLOCK_SYSTEM_SELECT    <= CODE_INT_NTSC_510;
            MAINS_LOCKED_SYNC      <= 1'b0;
            SUBCARRIER_LOCKED      <= 1'b0;
            DIVIDED_VERTICAL_PULSE <= 1'b0;
        end else begin
            PHASE_COMPARE_OUT      <= pc_q ^ ctrl_q.phase_out_invert;
            CLK_SRC_LINE_LOCK      <= line_lock;
            CLK_SRC_CRYSTAL        <= ~line_lock;
            CLOCK_SYSTEM_SELECT    <= clock_code(line_lock, ctrl_q.pal,
                                                 ctrl_q.pix760);
            MAINS_LOCKED_SYNC      <= line_lock;
            // no subcarrier lock logic exists, so in line lock the flag stays low
            SUBCARRIER_LOCKED      <= 1'b0;
            DIVIDED_VERTICAL_PULSE <= vpulse_q;
        end
    end

    always_comb begin
        status = '0;
        status[STAT_PRESENT_BIT]                 = present_q;
        status[STAT_LINELOCK_BIT]                = line_lock;
        status[STAT_CODE_LSB +: 4]               = CLOCK_SYSTEM_SELECT;
        status[STAT_SUBC_LOCK_BIT]               = SUBCARRIER_LOCKED;
        status[STAT_CLK_SRC_BIT]                 = CLK_SRC_LINE_LOCK;
    end

    // unmapped and write-only addresses read zero
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            RD_DATA <= '0;
        end else if (BUS_REQ.rd) begin
            case (BUS_REQ.addr)
                ADDR_CTRL:   RD_DATA <= {26'h0, ctrl_q};
                ADDR_VSHIFT: RD_DATA <= {22'h0, vphase_q};
                ADDR_PRESET: RD_DATA <= {22'h0, preset_q};
                ADDR_STATUS: RD_DATA <= status;
                default:     RD_DATA <= '0;
            endcase
        end else begin
            RD_DATA <= '0;
        end
    end

endmodule : vss_sync_source_select

/* File: shared/vss_pkg.sv */
// constants, register map and carrier types for the video sync source select block
// assumes one 10 MHz system clock and a simple strobe register port
package vss_pkg;

    localparam int unsigned CLK_HZ              = 10000000;
    localparam int unsigned MAINS_TIMEOUT_MS    = 40;
    localparam int unsigned MAINS_TIMEOUT_CYC   = MAINS_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int unsigned TIMEOUT_CNT_W       = 24;

    localparam int unsigned ADDR_W              = 8;
    localparam int unsigned DATA_W              = 32;
    localparam int unsigned VPHASE_W            = 10;
    localparam int unsigned LINE_CNT_W          = 12;

    localparam logic [7:0]  ADDR_CTRL           = 8'h00;
    localparam logic [7:0]  ADDR_VSHIFT         = 8'h04;
    localparam logic [7:0]  ADDR_PRESET         = 8'h08;
    localparam logic [7:0]  ADDR_SHIFT_CMD      = 8'h0C;
    localparam logic [7:0]  ADDR_STATUS         = 8'h10;

    // control word bit positions
    localparam int unsigned CTRL_SYNC_SRC_BIT   = 0;
    localparam int unsigned CTRL_AUTO_BIT       = 1;
    localparam int unsigned CTRL_PLL_PATH_BIT   = 2;
    localparam int unsigned CTRL_INVERT_BIT     = 3;
    localparam int unsigned CTRL_PAL_BIT        = 4;
    localparam int unsigned CTRL_PIX760_BIT     = 5;
    localparam logic [5:0]  CTRL_RESET          = 6'h00;

    // shift command bit positions
    localparam int unsigned CMD_UP_BIT          = 0;
    localparam int unsigned CMD_DOWN_BIT        = 1;
    localparam int unsigned CMD_PRESET_BIT      = 2;

    // status bit positions
    localparam int unsigned STAT_PRESENT_BIT    = 0;
    localparam int unsigned STAT_LINELOCK_BIT   = 1;
    localparam int unsigned STAT_CODE_LSB       = 4;
    localparam int unsigned STAT_SUBC_LOCK_BIT  = 8;
    localparam int unsigned STAT_CLK_SRC_BIT    = 9;

    localparam logic [9:0]  VPHASE_RESET        = 10'h000;
    localparam logic [9:0]  PRESET_RESET        = 10'h000;

    // clock system select codes
    localparam logic [3:0]  CODE_INT_NTSC_510   = 4'h0;
    localparam logic [3:0]  CODE_INT_NTSC_760   = 4'h6;
    localparam logic [3:0]  CODE_INT_PAL_510    = 4'h3;
    localparam logic [3:0]  CODE_INT_PAL_760    = 4'h9;
    localparam logic [3:0]  CODE_LL_NTSC_510    = 4'h2;
    localparam logic [3:0]  CODE_LL_NTSC_760    = 4'h8;
    localparam logic [3:0]  CODE_LL_PAL_510     = 4'h5;
    localparam logic [3:0]  CODE_LL_PAL_760     = 4'hB;

    // default divider ratios, sized for inputs sampled at the system clock
    localparam logic [11:0] XTAL_LINE_DIV       = 12'h008;
    localparam logic [11:0] MASTER_LINE_DIV     = 12'h008;
    localparam logic [11:0] LINES_PER_FIELD     = 12'h106;

    typedef struct packed {
        logic pix760;
        logic pal;
        logic phase_out_invert;
        logic pll_path_select;
        logic auto_switch_enable;
        logic sync_source_select;
    } vss_ctrl_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } vss_bus_req_type;

endpackage : vss_pkg

/* File: bench/vss_checker_asserts.sv */
// assertions on the top ports of the sync source select block
// assumes vss_pkg is compiled first; attached by the bind at the foot
`timescale 1ns/10ps
module vss_checker #(
    parameter int unsigned MAINS_TIMEOUT_CYCLES = 200
) (
    input wire logic                       SYS_CLK,
    input wire logic                       SYS_RST,
    input wire vss_pkg::vss_bus_req_type   BUS_REQ,
    input wire logic [vss_pkg::DATA_W-1:0] RD_DATA,
    input wire logic                       CLK_SRC_LINE_LOCK,
    input wire logic                       CLK_SRC_CRYSTAL,
    input wire logic [3:0]                 CLOCK_SYSTEM_SELECT,
    input wire logic                       MAINS_LOCKED_SYNC,
    input wire logic                       SUBCARRIER_LOCKED,
    input wire logic                       DIVIDED_VERTICAL_PULSE
);
    import vss_pkg::*;
    default clocking dc @(posedge SYS_CLK);
    endclocking
    default disable iff (SYS_RST);
    logic       man_wr;
    logic [5:0] wd;
    // only manual writes are tied to a fixed outcome; auto mode follows the mains pin
    assign man_wr = BUS_REQ.wr && BUS_REQ.addr == ADDR_CTRL && !BUS_REQ.wdata[CTRL_AUTO_BIT];
    assign wd     = BUS_REQ.wdata[5:0];

    AST_NO_SUBC: assert property (
        !SUBCARRIER_LOCKED) else $error("subcarrier lock claimed");
    AST_SRC_PAIR: assert property (
        CLK_SRC_CRYSTAL != CLK_SRC_LINE_LOCK) else $error("source pins not complementary");
    AST_SRC_MODE: assert property (
        CLK_SRC_LINE_LOCK == MAINS_LOCKED_SYNC) else $error("source pin disagrees with mode");
    AST_INT_CODES: assert property (
        !MAINS_LOCKED_SYNC |-> CLOCK_SYSTEM_SELECT inside {4'h0, 4'h3, 4'h6, 4'h9})
        else $error("internal sync with a foreign code");
    AST_LOCK_CODES: assert property (
        MAINS_LOCKED_SYNC |-> CLOCK_SYSTEM_SELECT inside {4'h2, 4'h5, 4'h8, 4'hB})
        else $error("mains lock with a foreign code");
    AST_MANUAL_MODE: assert property (
        man_wr |-> ##2 MAINS_LOCKED_SYNC == ($past(wd[0], 2) | $past(wd[2], 2)))
        else $error("manual source select not followed");
    AST_CODE_FOLLOWS: assert property (
        man_wr |-> ##2 CLOCK_SYSTEM_SELECT == 4'(3 * $past(wd[4], 2) + 6 * $past(wd[5], 2)
            + 2 * ($past(wd[0], 2) | $past(wd[2], 2))))
        else $error("clock system code wrong");
    AST_STATUS_SUBC: assert property (
        BUS_REQ.rd && BUS_REQ.addr == ADDR_STATUS |=> !RD_DATA[STAT_SUBC_LOCK_BIT])
        else $error("status shows subcarrier lock");
    AST_VPULSE_ONE: assert property (
        $rose(DIVIDED_VERTICAL_PULSE) |=> !DIVIDED_VERTICAL_PULSE)
        else $error("vertical pulse longer than one cycle");
endmodule : vss_checker

bind vss_sync_source_select vss_checker #(.MAINS_TIMEOUT_CYCLES(MAINS_TIMEOUT_CYCLES)) chk_u (
    .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .BUS_REQ(BUS_REQ), .RD_DATA(RD_DATA),
    .CLK_SRC_LINE_LOCK(CLK_SRC_LINE_LOCK), .CLK_SRC_CRYSTAL(CLK_SRC_CRYSTAL),
    .CLOCK_SYSTEM_SELECT(CLOCK_SYSTEM_SELECT), .MAINS_LOCKED_SYNC(MAINS_LOCKED_SYNC),
    .SUBCARRIER_LOCKED(SUBCARRIER_LOCKED), .DIVIDED_VERTICAL_PULSE(DIVIDED_VERTICAL_PULSE));

/* File: bench/vss_far_side_model.sv */
// far side: crystal, master oscillators and mains wave shaper
// assumes every wave is a whole number of sys_clk cycles, slow enough for 2-flop sampling
`timescale 1ns/10ps
module vss_far_side_model #(
    parameter int XT_HALF = 3,
    parameter int XO_HALF = 2,
    parameter int LC_HALF = 3,
    parameter int MN_HALF = 50
) (
    input  wire logic sys_clk,
    input  wire logic xt_run,
    input  wire logic vco_run,
    input  wire logic mn_run,
    input  wire logic pal,
    input  wire logic use_lc,
    output      logic xt_clk,
    output      logic m_clk,
    output      logic mains
);
    int xt_n = 0;
    int m_n = 0;
    int mn_n = 0;
    int m_half;
    int mn_half;
    // scaled mains: the 50 Hz wave has 6/5 the period of the 60 Hz one
    assign mn_half = pal ? MN_HALF * 6 / 5 : MN_HALF;
    assign m_half  = use_lc ? LC_HALF : XO_HALF;
    initial begin
        xt_clk = 1'b0;
        m_clk = 1'b0;
        mains = 1'b0;
    end
    // a stopped source rests low, as the shaper's pull-down leaves it
    always @(posedge sys_clk) begin
        xt_n <= (xt_n >= XT_HALF - 1) ? 0 : xt_n + 1;
        m_n <= (m_n >= m_half - 1) ? 0 : m_n + 1;
        mn_n <= (mn_n >= mn_half - 1) ? 0 : mn_n + 1;
        xt_clk <= xt_run & (xt_clk ^ (xt_n >= XT_HALF - 1));
        m_clk <= vco_run & (m_clk ^ (m_n >= m_half - 1));
        mains <= mn_run & (mains ^ (mn_n >= mn_half - 1));
    end
endmodule : vss_far_side_model

/* File: bench/testbench.sv */
// bench for the sync source select block: register tasks against the far side model
// assumes vss_pkg, the design, the checker and the far side model are compiled first
`timescale 1ns/10ps
module testbench;
    import vss_pkg::*;
    localparam int LINE_CYC = 4 * int'(MASTER_LINE_DIV);
    logic              sys_clk, sys_rst, pco, src_lock, src_xtal, locked, vpulse;
    logic              xt_run, vco_run, mn_run, pal_m, xt_clk, m_clk, mains;
    vss_bus_req_type   req;
    logic [DATA_W-1:0] rd_data, e;
    logic [3:0]        code;
    int                mismatches = 0;
    int                total_checks = 0;
    int                cyc = 0;
    int                t0, t1, t2;

    vss_sync_source_select #(.MAINS_TIMEOUT_CYCLES(200)) dut_u (
        .SYS_CLK(sys_clk), .SYS_RST(sys_rst), .BUS_REQ(req), .RD_DATA(rd_data),
        .REFERENCE_CRYSTAL_CLOCK(xt_clk), .MASTER_VIDEO_CLOCK(m_clk),
        .MAINS_REFERENCE_INPUT(mains), .PHASE_COMPARE_OUT(pco), .CLK_SRC_LINE_LOCK(src_lock),
        .CLK_SRC_CRYSTAL(src_xtal), .CLOCK_SYSTEM_SELECT(code), .MAINS_LOCKED_SYNC(locked),
        .SUBCARRIER_LOCKED(), .DIVIDED_VERTICAL_PULSE(vpulse));
    vss_far_side_model far_u (.sys_clk(sys_clk), .xt_run(xt_run), .vco_run(vco_run),
        .mn_run(mn_run), .pal(pal_m), .use_lc(src_lock), .xt_clk(xt_clk), .m_clk(m_clk),
        .mains(mains));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic ws(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : ws
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = '1);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1;
        chk(rd_data & m, x);
    endtask : rdc
    // the pulse is one cycle long, so it is looked at once per cycle
    task automatic wait_vp(output int t);
        int n;
        n = 0;
        // step off the edge first: a caller that returns on an edge would race the pulse
        #1;
        while (vpulse !== 1'b1 && n < 9000) begin
            ws(1);
            n++;
        end
        t = cyc;
        ws(1);
    endtask : wait_vp

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            mismatches++;
            end_of_test();
        end
    end

    initial begin
        sys_rst = 1'b1;
        req = '0;
        {xt_run, vco_run, mn_run, pal_m} = 4'b1100;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        ws(2);
        rdc(ADDR_CTRL, 32'h0);
        chk(32'({src_xtal, code}), 32'h10);
        $display("test reset done");
        // code = 3*pal + 6*pix760 + 2*mains lock reproduces both code tables
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_CTRL, 32'({i[0], i[1], 4'h0}));
            wr(ADDR_CTRL, 32'({i[0], i[1], 3'h0, i[2]}));
            ws(3);
            e = 32'({i[2], i[2], 4'(3 * i[1] + 6 * i[0] + 2 * i[2])});
            chk(32'({locked, src_lock, code}), e);
        end
        wr(ADDR_CTRL, 32'h14);
        ws(3);
        chk(32'({locked, code}), 32'h15);
        $display("test codes done");
        wr(ADDR_VSHIFT, 32'h3FF);
        rdc(ADDR_VSHIFT, 32'h3FF);
        wr(ADDR_SHIFT_CMD, 32'h1);
        rdc(ADDR_VSHIFT, 32'h0);
        wr(ADDR_SHIFT_CMD, 32'h2);
        rdc(ADDR_VSHIFT, 32'h3FF);
        wr(ADDR_PRESET, 32'h2A5);
        wr(ADDR_SHIFT_CMD, 32'h7);
        rdc(ADDR_VSHIFT, 32'h2A5);
        rdc(ADDR_SHIFT_CMD, 32'h0);
        rdc(8'h40, 32'h0);
        $display("test shift done");
        wr(ADDR_CTRL, 32'h0);
        vco_run <= 1'b0;
        ws(80);
        chk(32'(pco), 32'h1);
        wr(ADDR_CTRL, 32'h8);
        ws(3);
        chk(32'(pco), 32'h0);
        xt_run <= 1'b0;
        vco_run <= 1'b1;
        ws(80);
        chk(32'(pco), 32'h1);
        wr(ADDR_CTRL, 32'h1);
        vco_run <= 1'b0;
        mn_run <= 1'b1;
        ws(150);
        chk(32'(pco), 32'h1);
        vco_run <= 1'b1;
        $display("test comparator done");
        wr(ADDR_CTRL, 32'h0);
        ws(3);
        chk(32'(locked), 32'h0);
        pal_m <= 1'b1;
        wr(ADDR_CTRL, 32'h12);
        ws(300);
        chk(32'({locked, code}), 32'h15);
        rdc(ADDR_STATUS, 32'h53, 32'h1F3);
        mn_run <= 1'b0;
        ws(500);
        chk(32'({locked, src_xtal, code}), 32'h13);
        $display("test auto done");
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_VSHIFT, 32'h0);
        wait_vp(t0);
        wait_vp(t1);
        chk(32'(t1 - t0), 32'(int'(LINES_PER_FIELD) * LINE_CYC));
        wr(ADDR_VSHIFT, 32'h105);
        wait_vp(t2);
        chk(32'(t2 - t1), 32'(261 * LINE_CYC));
        $display("test vertical done");
        end_of_test();
    end
endmodule : testbench
